// ---- logic/mas_map.svh ----
// register offsets, field positions, reset values and full-scale codes of the monitor alert block
`ifndef MAS_MAP_SVH
`define MAS_MAP_SVH

// ----------------------------------------------------------------
// register offsets (register pointer values)
// ----------------------------------------------------------------
`define MAS_ADDR_STATUS     8'h02
`define MAS_ADDR_ALERT      8'h03
`define MAS_ADDR_SHUNT      8'h04

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MAS_RST_STATUS      16'h0000
`define MAS_RST_ALERT       16'h0000
`define MAS_RST_SHUNT       16'h0000
`define MAS_RST_RDATA       16'h0000

// ----------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------
`define MAS_BIT_LIM_TOP     15
`define MAS_BIT_REM3        7
`define MAS_BIT_PWR_RDY     6
`define MAS_BIT_TEMP_RDY    5
`define MAS_BIT_BROWNOUT    4
`define MAS_BIT_ALERT_ACT   3
`define MAS_BIT_MATH_OVF    2
`define MAS_BIT_MASK_LO     4

// ----------------------------------------------------------------
// alert mask and control field positions
// ----------------------------------------------------------------
`define MAS_BIT_FAULT_CNT   2
`define MAS_BIT_POLARITY    1
`define MAS_BIT_LATCH       0

// ----------------------------------------------------------------
// shunt full-scale codes per gain
// ----------------------------------------------------------------
`define MAS_FS_POS_DIV8     16'h7d00
`define MAS_FS_NEG_DIV8     16'h8300
`define MAS_FS_POS_DIV4     16'h3e80
`define MAS_FS_NEG_DIV4     16'hc180
`define MAS_FS_POS_DIV2     16'h1f40
`define MAS_FS_NEG_DIV2     16'he0c0
`define MAS_FS_POS_DIV1     16'h0fa0
`define MAS_FS_NEG_DIV1     16'hf060

`endif

// ---- logic/mas_pkg.sv ----
// types shared by the monitor alert block
package mas_pkg;

	// alert mode selected by the latch control bit
	typedef enum logic {
		MAS_MODE_TRANSP = 1'b0,
		MAS_MODE_LATCH  = 1'b1
	} mas_mode_t;

	// shunt gain setting
	typedef enum logic [1:0] {
		MAS_PGA_DIV1 = 2'b00,
		MAS_PGA_DIV2 = 2'b01,
		MAS_PGA_DIV4 = 2'b10,
		MAS_PGA_DIV8 = 2'b11
	} mas_pga_t;

	// whole state of the top module
	typedef struct packed {
		logic [15:0] stat;
		logic [15:0] mask;
		logic [15:0] shunt;
		logic        bo_pend;
		logic        rem3_clr_ok;
		logic        alert_pin;
		logic [15:0] rd_data;
		logic        rd_valid;
	} mas_state_t;

endpackage

// ---- logic/mas_flt_if.sv ----
// signals between the flag logic and the fault-count filter
`timescale 1ns/100ps
interface mas_flt_if #(parameter int N_CH = 9);
	logic            upd;
	logic [1:0]      fault_cnt;
	logic [N_CH-1:0] viol;
	logic [N_CH-1:0] qual;
	logic            qual_upd;

	modport src (output upd, fault_cnt, viol, input qual, qual_upd);
	modport flt (input upd, fault_cnt, viol, output qual, qual_upd);
endinterface // mas_flt_if

// ---- logic/mas_fault_filter.sv ----
// consecutive-violation filter for the limit flags
`timescale 1ns/100ps
module mas_fault_filter
	import mas_pkg::*;
#(
	parameter int N_CH  = 9,
	parameter int CNT_W = 4
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// filter side of the carrier
	mas_flt_if.flt   flt
);

	typedef struct packed {
		logic [N_CH-1:0][CNT_W-1:0] cnt;
		logic [N_CH-1:0]            qual;
		logic                       upd;
	} mas_flt_state_t;

	mas_flt_state_t st_q;
	mas_flt_state_t st_d;
	logic [CNT_W-1:0] need;

	// counter must reach 8 without wrapping
	if (CNT_W < 4) begin : g_chk
		$error("mas_fault_filter: CNT_W must be at least 4");
	end

	// codes 00/01/10/11 ask for 1/2/4/8 results in a row
	assign need = CNT_W'(1) << flt.fault_cnt;

	// count saturates at the target so a long fault never wraps
	always_comb begin
		st_d     = st_q;
		st_d.upd = flt.upd;
		for (int i = 0; i < N_CH; i++) begin
			if (flt.upd) begin
				if (flt.viol[i]) begin
					if (st_q.cnt[i] < need)
						st_d.cnt[i] = st_q.cnt[i] + CNT_W'(1);
					st_d.qual[i] = (st_d.cnt[i] >= need);
				end else begin
					st_d.cnt[i]  = '0;
					st_d.qual[i] = 1'b0;
				end
			end
		end
	end

	// state register
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign flt.qual     = st_q.qual;
	assign flt.qual_upd = st_q.upd;

endmodule // mas_fault_filter

// ---- logic/mas_alert_top.sv ----
// status flags, alert mask/control and shunt result register of the monitor
//
// Summary of operation
// - remote 3 flag sets on overlimit or open diode
// - transparent: remote 3 clears below limit, no open
// - power ready flag sets when power cycle done
// - power ready clears on one-shot write or read
// - temp ready: set when channels done, same clears
// - latch: brown-out error set at conversion end
// - alert flag mirrors alert, clears per mode
// - math overflow flag never drives alert
// - mask bits 4-15 gate flags, not setting
// - mask zero blocks flag, one passes it
// - fault count needs 1,2,4,8 consecutive violations
// - polarity bit: zero active low, one high
// - transparent: alert drops with cause, ignores response
// - latch: alert holds until read, response, mask
// - shunt stored sign-extended sixteen-bit two's complement
// - divide-by-8: one sign bit, limits 7d00/8300
// - divide-by-4: two sign bits, 3e80/c180
// - divide-by-2: three sign bits, 1f40/e0c0
// - divide-by-1: four sign bits, 0fa0/f060
// - latch: limit flags clear on read, reset later
`timescale 1ns/100ps
`include "mas_map.svh"
module mas_alert_top
	import mas_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	// register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [15:0] i_reg_wdata,
	input  wire logic        i_reg_rd,
	output logic      [15:0] o_reg_rdata,
	output logic             o_reg_rvalid,
	// limit comparison results
	input  wire logic        i_limit_upd,
	input  wire logic [7:0]  i_limit_viol,
	input  wire logic        i_rem3_over,
	input  wire logic        i_rem3_under,
	input  wire logic        i_rem3_open,
	// conversion and arithmetic events
	input  wire logic        i_pwr_done,
	input  wire logic        i_temp_done,
	input  wire logic        i_brownout,
	input  wire logic        i_math_ovf,
	input  wire logic        i_oneshot_wr,
	input  wire logic        i_alert_resp,
	// shunt result
	input  wire logic        i_shunt_upd,
	input  wire logic [15:0] i_shunt_code,
	input  wire logic [1:0]  i_pga,
	// alert pin
	output logic             o_alert
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mas_state_t st_q;
	mas_state_t st_d;
	mas_flt_if #(.N_CH(9)) flt ();
	logic stat_rd;
	logic mask_wr;
	logic cause_q;
	mas_mode_t mode;

	// clamp the raw code to the full scale of the gain; sign bits follow
	function automatic logic [15:0] mas_clamp(input logic [15:0] code, input logic [1:0] pga);
		logic [15:0] pos;
		logic [15:0] neg;
		pos = `MAS_FS_POS_DIV1;
		neg = `MAS_FS_NEG_DIV1;
		case (mas_pga_t'(pga))
			MAS_PGA_DIV8: begin
				pos = `MAS_FS_POS_DIV8;
				neg = `MAS_FS_NEG_DIV8;
			end
			MAS_PGA_DIV4: begin
				pos = `MAS_FS_POS_DIV4;
				neg = `MAS_FS_NEG_DIV4;
			end
			MAS_PGA_DIV2: begin
				pos = `MAS_FS_POS_DIV2;
				neg = `MAS_FS_NEG_DIV2;
			end
			MAS_PGA_DIV1: begin
				pos = `MAS_FS_POS_DIV1;
				neg = `MAS_FS_NEG_DIV1;
			end
			default: begin
				pos = `MAS_FS_POS_DIV1;
				neg = `MAS_FS_NEG_DIV1;
			end
		endcase
		if ($signed(code) > $signed(pos))
			return pos;
		else if ($signed(code) < $signed(neg))
			return neg;
		else
			return code;
	endfunction

	// unmasked-flag term over mask positions 4 to 15
	function automatic logic mas_cause(input logic [15:0] stat, input logic [15:0] mask);
		return |(stat[15:`MAS_BIT_MASK_LO] & mask[15:`MAS_BIT_MASK_LO]);
	endfunction

	// ----------------------------------------------------------------
	// fault-count filter for flags 15 down to 7
	// ----------------------------------------------------------------
	assign flt.upd       = i_limit_upd;
	assign flt.fault_cnt = st_q.mask[`MAS_BIT_FAULT_CNT+1:`MAS_BIT_FAULT_CNT];
	assign flt.viol      = {i_limit_viol, i_rem3_over | i_rem3_open};

	mas_fault_filter #(
		.N_CH  (9),
		.CNT_W (4)
	) u_filter (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.flt       (flt)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	assign stat_rd = i_reg_rd && (i_reg_addr == `MAS_ADDR_STATUS);
	assign mask_wr = i_reg_wr && (i_reg_addr == `MAS_ADDR_ALERT);
	assign mode    = mas_mode_t'(st_q.mask[`MAS_BIT_LATCH]);
	assign cause_q = mas_cause(st_q.stat, st_q.mask);

	// ----------------------------------------------------------------
	// next state: clears are applied first so that sets win
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;

		// status read clears latched limit flags and the event flags
		if (stat_rd) begin
			if (mode == MAS_MODE_LATCH)
				st_d.stat[15:`MAS_BIT_REM3] = '0;
			st_d.stat[`MAS_BIT_PWR_RDY]  = 1'b0;
			st_d.stat[`MAS_BIT_TEMP_RDY] = 1'b0;
			st_d.stat[`MAS_BIT_BROWNOUT] = 1'b0;
			st_d.stat[`MAS_BIT_MATH_OVF] = 1'b0;
		end
		if (i_oneshot_wr) begin
			st_d.stat[`MAS_BIT_PWR_RDY]  = 1'b0;
			st_d.stat[`MAS_BIT_TEMP_RDY] = 1'b0;
		end

		// remember whether the newest remote 3 result may clear the flag
		if (i_limit_upd)
			st_d.rem3_clr_ok = i_rem3_under && !i_rem3_open;

		// limit flags update one cycle after the filter samples
		if (flt.qual_upd) begin
			for (int i = 1; i < 9; i++) begin
				if (mode == MAS_MODE_LATCH)
					st_d.stat[`MAS_BIT_REM3+i] = st_d.stat[`MAS_BIT_REM3+i] | flt.qual[i];
				else
					st_d.stat[`MAS_BIT_REM3+i] = flt.qual[i];
			end
			// hysteresis: between the two thresholds the flag holds
			if (flt.qual[0])
				st_d.stat[`MAS_BIT_REM3] = 1'b1;
			else if (mode == MAS_MODE_TRANSP && st_q.rem3_clr_ok)
				st_d.stat[`MAS_BIT_REM3] = 1'b0;
		end

		// ready flags
		if (i_pwr_done)
			st_d.stat[`MAS_BIT_PWR_RDY] = 1'b1;
		if (i_temp_done)
			st_d.stat[`MAS_BIT_TEMP_RDY] = 1'b1;

		// brown-out is remembered through the conversion, flagged at its end in latch mode only
		if (i_pwr_done) begin
			st_d.bo_pend = 1'b0;
			if (mode == MAS_MODE_LATCH && (st_q.bo_pend || i_brownout))
				st_d.stat[`MAS_BIT_BROWNOUT] = 1'b1;
		end else if (i_brownout) begin
			st_d.bo_pend = 1'b1;
		end

		// overflow is outside the mask range, so it cannot reach the alert
		if (i_math_ovf)
			st_d.stat[`MAS_BIT_MATH_OVF] = 1'b1;

		// mask and control register
		if (mask_wr)
			st_d.mask = i_reg_wdata;

		// shunt result
		if (i_shunt_upd)
			st_d.shunt = mas_clamp(i_shunt_code, i_pga);

		// alert: transparent follows the cause, latch holds until released
		if (st_d.mask[`MAS_BIT_LATCH] == MAS_MODE_LATCH) begin
			st_d.stat[`MAS_BIT_ALERT_ACT] = mas_cause(st_d.stat, st_d.mask)
				| (st_q.stat[`MAS_BIT_ALERT_ACT] && !stat_rd && !i_alert_resp && !mask_wr);
		end else begin
			st_d.stat[`MAS_BIT_ALERT_ACT] = mas_cause(st_d.stat, st_d.mask);
		end
		st_d.stat[1:0] = 2'b00;

		// pin level from the new polarity so it never glitches a cycle late
		st_d.alert_pin = st_d.mask[`MAS_BIT_POLARITY] ? st_d.stat[`MAS_BIT_ALERT_ACT]
			: !st_d.stat[`MAS_BIT_ALERT_ACT];

		// read data returns the value before any read side effect
		st_d.rd_valid = i_reg_rd;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`MAS_ADDR_STATUS: st_d.rd_data = st_q.stat;
				`MAS_ADDR_ALERT:  st_d.rd_data = st_q.mask;
				`MAS_ADDR_SHUNT:  st_d.rd_data = st_q.shunt;
				default:          st_d.rd_data = 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			st_q <= '{stat: `MAS_RST_STATUS, mask: `MAS_RST_ALERT, shunt: `MAS_RST_SHUNT,
				bo_pend: 1'b0, rem3_clr_ok: 1'b0, alert_pin: 1'b1,
				rd_data: `MAS_RST_RDATA, rd_valid: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_reg_rdata  = st_q.rd_data;
	assign o_reg_rvalid = st_q.rd_valid;
	assign o_alert      = st_q.alert_pin;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_rd_status;
		i_reg_rd && i_reg_addr == `MAS_ADDR_STATUS;
	endsequence

	sequence s_no_release;
		!i_reg_rd && !i_alert_resp && !i_reg_wr;
	endsequence

	AST_REM3_SET: assert property (flt.qual_upd && flt.qual[0] |=> st_q.stat[`MAS_BIT_REM3])
		else $error("remote 3 flag did not set");

	AST_REM3_HOLD: assert property (mode == MAS_MODE_TRANSP && st_q.stat[`MAS_BIT_REM3]
		&& flt.qual_upd && !st_q.rem3_clr_ok |=> st_q.stat[`MAS_BIT_REM3])
		else $error("remote 3 flag cleared inside hysteresis");

	AST_PWR_RDY_SET: assert property (i_pwr_done ##1 1'b1 |-> st_q.stat[`MAS_BIT_PWR_RDY])
		else $error("power ready flag not set");

	AST_PWR_RDY_CLR: assert property (i_oneshot_wr && !i_pwr_done |=> !st_q.stat[`MAS_BIT_PWR_RDY])
		else $error("power ready flag not cleared by one-shot");

	AST_TEMP_RDY: assert property (s_rd_status and !i_temp_done
		|=> !st_q.stat[`MAS_BIT_TEMP_RDY])
		else $error("temperature ready flag not cleared by read");

	// the brown-out may come in any earlier cycle of the conversion or in its last one
	AST_BROWNOUT: assert property (mode == MAS_MODE_LATCH && i_pwr_done
		&& (i_brownout || st_q.bo_pend) |=> st_q.stat[`MAS_BIT_BROWNOUT])
		else $error("brown-out error not flagged at conversion end");

	AST_ALERT_MIRROR: assert property (cause_q |-> st_q.stat[`MAS_BIT_ALERT_ACT])
		else $error("unmasked flag without alert");

	AST_TRANSP_DROP: assert property (mode == MAS_MODE_TRANSP && !cause_q
		|-> !st_q.stat[`MAS_BIT_ALERT_ACT])
		else $error("transparent alert without cause");

	AST_LATCH_HOLD: assert property (mode == MAS_MODE_LATCH && st_q.stat[`MAS_BIT_ALERT_ACT]
		and s_no_release |=> st_q.stat[`MAS_BIT_ALERT_ACT])
		else $error("latched alert released without cause");

	AST_POLARITY: assert property (o_alert == (st_q.mask[`MAS_BIT_POLARITY]
		? st_q.stat[`MAS_BIT_ALERT_ACT] : !st_q.stat[`MAS_BIT_ALERT_ACT]))
		else $error("alert pin polarity wrong");

	AST_OVF_QUIET: assert property (st_q.stat[`MAS_BIT_MATH_OVF] && !cause_q && mode == MAS_MODE_TRANSP
		|-> o_alert != st_q.mask[`MAS_BIT_POLARITY])
		else $error("overflow drove the alert");

	AST_READ_CLR: assert property (mode == MAS_MODE_LATCH && !mask_wr and s_rd_status and !flt.qual_upd
		|=> st_q.stat[15:`MAS_BIT_REM3] == 9'h000)
		else $error("latched limit flags survived a status read");

	AST_SHUNT_DIV1: assert property (i_shunt_upd && i_pga == MAS_PGA_DIV1
		&& $signed(i_shunt_code) > $signed(16'h0fa0) |=> st_q.shunt == 16'h0fa0)
		else $error("divide-by-1 positive clamp wrong");

	AST_SHUNT_DIV8: assert property (i_shunt_upd && i_pga == MAS_PGA_DIV8
		&& $signed(i_shunt_code) < $signed(16'h8300) |=> st_q.shunt == 16'h8300)
		else $error("divide-by-8 negative clamp wrong");

endmodule // mas_alert_top

// ---- tb/mas_host_model.sv ----
// host model that answers an active alert with an alert response
`timescale 1ns/100ps
module mas_host_model (
	// clock
	input  wire logic       i_ref_clk,
	// control from the bench
	input  wire logic       i_en,
	input  wire logic [3:0] i_dly,
	input  wire logic       i_pol,
	// alert pin and response
	input  wire logic       i_alert,
	output logic            o_resp
);
	int n = 0;

	initial o_resp = 1'b0;

	// one response pulse after the alert has been active for i_dly cycles
	always @(posedge i_ref_clk) begin
		n <= (i_en && i_alert == i_pol) ? n + 1 : 0;
		o_resp <= i_en && i_alert == i_pol && n == int'(i_dly);
	end
endmodule // mas_host_model

// ---- tb/monitor_alert_status_logic_tb.sv ----
// self-checking bench of the monitor alert block with a status model
`timescale 1ns/100ps
module monitor_alert_status_logic_tb;
	logic        clk;
	logic        rst_b;
	logic [7:0]  addr;
	logic        reg_wr;
	logic [15:0] wd;
	logic        reg_rd;
	logic [15:0] rdata;
	logic        rvalid;
	logic        upd;
	logic [7:0]  viol;
	logic        over;
	logic        under;
	logic        opn;
	logic [4:0]  evs;
	logic        shupd;
	logic [15:0] scode;
	logic [1:0]  pga;
	logic        alert;
	logic        resp;
	logic        hen;
	logic [3:0]  hdly;
	logic [15:0] ms;
	logic [15:0] mm;
	logic        bp;
	int          cnt [9];
	int          num_errors = 0;
	int          checks = 0;

	always #2 clk = ~clk;

	mas_alert_top u_mas_alert_top (
		.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(reg_wr),
		.i_reg_wdata(wd), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_limit_upd(upd), .i_limit_viol(viol), .i_rem3_over(over), .i_rem3_under(under),
		.i_rem3_open(opn), .i_pwr_done(evs[0]), .i_temp_done(evs[1]), .i_brownout(evs[2]),
		.i_math_ovf(evs[3]), .i_oneshot_wr(evs[4]), .i_alert_resp(resp),
		.i_shunt_upd(shupd), .i_shunt_code(scode), .i_pga(pga), .o_alert(alert));

	mas_host_model u_mas_host_model (
		.i_ref_clk(clk), .i_en(hen), .i_dly(hdly), .i_pol(mm[1]), .i_alert(alert), .o_resp(resp));

	// ----------------------------------------------------------------
	// checking and model tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// latched alert holds unless released by read, response or mask write
	task automatic m_al(input bit rel);
		logic c;
		c = |(ms[15:4] & mm[15:4]);
		ms[3] = (mm[0] && !rel) ? (ms[3] | c) : c;
	endtask

	// look after the edge so the pin launched on it has settled
	task automatic ca();
		#1;
		chk({15'h0, alert}, {15'h0, mm[1] ? ms[3] : !ms[3]});
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({15'h0, rvalid}, 16'h0001);
		chk(rdata, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		if (a == 8'h03) begin
			mm = d;
			m_al(1);
		end
	endtask

	// status read: ready, brown-out and overflow always clear, limits in latch only
	task automatic rs();
		logic [15:0] e;
		e = ms;
		ms[6:4] = 3'h0;
		ms[2] = 1'b0;
		if (mm[0])
			ms[15:7] = 9'h000;
		m_al(1);
		rd(8'h02, e);
	endtask

	// conversion end of the limit comparators
	task automatic lu(input logic [8:0] v, input logic un, input logic op);
		int i;
		int b;
		@(posedge clk);
		upd <= 1'b1;
		viol <= v[7:0];
		over <= v[8];
		under <= un;
		opn <= op;
		@(posedge clk);
		upd <= 1'b0;
		v[8] = v[8] | op;
		for (i = 0; i < 9; i++) begin
			// count stops at the target, so a later larger fault count resumes from there
			cnt[i] = v[i] ? ((cnt[i] < (1 << mm[3:2])) ? cnt[i] + 1 : cnt[i]) : 0;
			b = (i == 8) ? 7 : 8 + i;
			if (cnt[i] >= (1 << mm[3:2]))
				ms[b] = 1'b1;
			else if (!mm[0] && (i < 8 || (un && !op)))
				ms[b] = 1'b0;
		end
		m_al(0);
		repeat (2) @(posedge clk);
	endtask

	// events: {oneshot, overflow, brown-out, temp done, power done}
	task automatic ev(input logic [4:0] e);
		@(posedge clk);
		evs <= e;
		@(posedge clk);
		evs <= 5'h00;
		if (e[2])
			bp = 1'b1;
		if (e[0]) begin
			ms[6] = 1'b1;
			ms[4] = ms[4] | (bp & mm[0]);
			bp = 1'b0;
		end
		if (e[1])
			ms[5] = 1'b1;
		if (e[3])
			ms[2] = 1'b1;
		if (e[4] && !e[0])
			ms[6] = 1'b0;
		if (e[4] && !e[1])
			ms[5] = 1'b0;
		m_al(0);
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int g;
		int k;
		int p;
		int v;
		int e;
		int fs;
		logic [8:0] lv;
		clk = 0;
		rst_b = 0;
		{addr, reg_wr, wd, reg_rd, upd, viol, over, under, opn, evs, shupd, scode, pga} = '0;
		{hen, hdly, ms, mm, bp} = '0;
		cnt = '{default: 0};
		void'($urandom(30));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h03, 16'h0000);
		rd(8'h04, 16'h0000);
		rd(8'h05, 16'h0000);
		ca();
		wr(8'h02, 16'hffff);
		rs();
		// shunt results at and beyond each gain's full scale
		for (g = 0; g < 4; g++) begin
			fs = 4000 << g;
			for (k = 0; k < 6; k++) begin
				v = (k == 5) ? int'($signed(16'($urandom))) : (k[0] ? fs + 1 : fs) * (k > 1 ? -1 : 1);
				e = (v > fs) ? fs : ((v < -fs) ? -fs : v);
				@(posedge clk);
				pga <= 2'(g);
				scode <= 16'(v);
				shupd <= 1'b1;
				@(posedge clk);
				shupd <= 1'b0;
				rd(8'h04, 16'(e));
			end
		end
		// every fault count in both modes, random traffic checked against the model
		for (p = 0; p < 8; p++) begin
			wr(8'h03, (16'($urandom) & 16'hfff2) | 16'h8000 | {12'h0, 2'(p >> 1), 1'b0, p[0]});
			ev(5'b00001);
			rs();
			repeat (30) begin
				k = $urandom_range(0, 9);
				lv = ($urandom_range(0, 3) == 0) ? 9'($urandom) : 9'h1ff;
				if (k < 5)
					lu(lv, $urandom_range(0, 1) && !lv[8], $urandom_range(0, 3) == 0);
				else if (k < 7)
					ev(5'($urandom));
				else if (k == 7)
					rs();
				else if (k == 8)
					wr(8'h03, (16'($urandom) & 16'hfff0) | {12'h0, mm[3:0]});
				else
					rd(8'h03, mm);
				ca();
			end
		end
		// latched alert outlives its cause until the host answers, prompt and slow
		for (k = 0; k < 2; k++) begin
			wr(8'h03, 16'h0021);
			rs();
			ev(5'b00010);
			ca();
			ev(5'b10000);
			ca();
			hdly <= k ? 4'h9 : 4'h0;
			hen <= 1'b1;
			for (g = 0; g < 40 && resp !== 1'b1; g++) begin
				@(posedge clk);
				#1;
			end
			if (resp !== 1'b1) begin
				num_errors++;
				final_report();
			end
			hen <= 1'b0;
			m_al(1);
			repeat (3) @(posedge clk);
			ca();
		end
		final_report();
	end

	initial begin
		#400000;
		num_errors++;
		final_report();
	end
endmodule // monitor_alert_status_logic_tb
